/* core/rx_lane_status_pkg.sv */
package rx_lane_status_pkg;
  localparam int LANES = 20;

  // lane marker table, index 0 last
  localparam logic [LANES-1:0][63:0] STD_MARKER = {
    64'hc0_f0_e5_00_3f_0f_1a_00, 64'h5f_66_2a_00_a0_99_d5_00,
    64'had_d6_b7_00_52_29_48_00, 64'hc4_31_4c_00_3b_ce_b3_00,
    64'h35_36_cd_00_ca_c9_32_00, 64'h83_c7_ca_00_7c_38_35_00,
    64'h1a_f8_bd_00_e5_07_42_00, 64'h5c_b9_b2_00_a3_46_4d_00,
    64'hb9_91_55_00_46_6e_aa_00, 64'hfd_6c_99_00_02_93_66_00,
    64'h68_c9_fb_00_97_36_04_00, 64'ha0_24_76_00_5f_db_89_00,
    64'h7b_45_66_00_84_ba_99_00, 64'h9a_4a_26_00_65_b5_d9_00,
    64'hdd_14_c2_00_22_eb_3d_00, 64'hf5_07_09_00_0a_f8_f6_00,
    64'h4d_95_7b_00_b2_6a_84_00, 64'h59_4b_e8_00_a6_b4_17_00,
    64'h9d_71_8e_00_62_8e_71_00, 64'hc1_68_21_00_3e_97_de_00};
  localparam logic [LANES-1:0][63:0] RX_MARKER_RESET = STD_MARKER;
  localparam logic [LANES-1:0][63:0] TX_MARKER_RESET = STD_MARKER;
  // parity bytes of a marker are not part of its identity
  localparam logic [63:0] MARKER_MASK = 64'hffffff00_ffffff00;
  localparam logic [1:0] HDR_CTRL = 2'h2;

  // lock and error thresholds
  localparam logic [6:0] LOCK_GOOD_LAST = 7'h3f;
  localparam logic [6:0] BER_WIN_LAST = 7'h3f;
  localparam logic [4:0] BER_BAD_LIMIT = 5'h10;
  localparam logic [2:0] REPEAT_LAST = 3'h3;
  localparam logic [2:0] ALIGN_TRIES_LAST = 3'h3;
  localparam logic [2:0] FERR_WIN_LAST = 3'h7;
  localparam logic [15:0] MF_LEN_RESET = 16'h4000;
  localparam logic [6:0] BAD_CODE_MAX = 7'h7f;

  // register map
  localparam int AW = 12;
  localparam logic [AW-1:0] REG_CTRL = 12'h000;
  localparam logic [AW-1:0] REG_SUMMARY = 12'h004;
  localparam logic [AW-1:0] REG_SYNCED = 12'h008;
  localparam logic [AW-1:0] REG_IRQ_STATUS = 12'h00c;
  localparam logic [AW-1:0] REG_IRQ_ENABLE = 12'h010;
  localparam logic [AW-1:0] REG_IRQ_CLEAR = 12'h014;
  localparam logic [3:0] PAGE_RX_MARKER = 4'h1;
  localparam logic [3:0] PAGE_TX_MARKER = 4'h2;
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_MF_LSB = 16;
  localparam int IRQ_W = 4;
  localparam int IRQ_SKEW = 0;
  localparam int IRQ_CRC = 1;
  localparam int IRQ_ALIGN = 2;
  localparam int IRQ_FAIL = 3;
  localparam logic [IRQ_W-1:0] IEN_RESET = 4'h0;

  typedef enum logic [1:0] {
    ERR_NONE = 2'b00,
    ERR_SYNC = 2'b01,
    ERR_RATE = 2'b10,
    ERR_REPEAT = 2'b11
  } lane_err_t;
endpackage

/* core/rx_lane_status.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - per-lane rx and tx marker values held
// - sync and alignment status on receive clock
// - synced only while markers arrive correctly
// - sync failure sticky until block relock or other
// - marker at wrong spacing sets rate error
// - four invalid markers set repeat error
// - one-cycle pulse per invalid marker after first marker found
// - aligned only when every lane synced
// - alignment error on failed tries or loss
// - skew pulse when markers not simultaneous
// - per-lane header error count with qualifier
// - per-position logical lane number output
// - demux bit once lane identified
// - block lock per lane from headers
// - link status is aligned and not high ber
// - local fault is OR of two faults
// - crc mismatch pulses one cycle
// - packet error on last cycle, crc part unless bypassed
// - count cycles in receive error state
module rx_lane_status
  import rx_lane_status_pkg::*;
(
  // clock and reset
  input logic clock,
  input logic rst,
  // lane words from the gearbox
  input logic [LANES-1:0][65:0] lane_block,
  input logic [LANES-1:0] lane_block_valid,
  // receive path conditions
  input logic high_bit_error_rate,
  input logic internal_local_fault,
  input logic received_local_fault,
  input logic rx_error_state,
  // packet end and crc check
  input logic pkt_valid,
  input logic pkt_eop,
  input logic pkt_err_in,
  input logic [31:0] crc_calc,
  input logic [31:0] crc_rx,
  // register port
  input logic [AW-1:0] addr,
  input logic [31:0] wdata,
  input logic wr,
  input logic rd,
  output logic [31:0] rdata,
  output logic irq,
  // lane status
  output logic [LANES-1:0] lane_block_lock,
  output logic [LANES-1:0] lane_word_synced,
  output logic [LANES-1:0] lane_sync_failure,
  output logic [LANES-1:0] marker_rate_error,
  output logic [LANES-1:0] marker_repeat_error,
  output logic [LANES-1:0] invalid_marker_pulse,
  output logic [LANES-1:0] lane_demux_found,
  output logic [LANES-1:0][4:0] lane_position_map,
  output logic [LANES-1:0][3:0] framing_err_count,
  output logic [LANES-1:0] framing_err_valid,
  // link summary
  output logic rx_aligned,
  output logic rx_aligned_error,
  output logic marker_skew_pulse,
  output logic rx_link_status,
  output logic rx_local_fault,
  output logic crc_mismatch_pulse,
  output logic packet_end_out,
  output logic packet_error_out,
  output logic [6:0] bad_code_count
);

  typedef struct packed {
    logic [LANES-1:0] lock;
    logic [LANES-1:0] synced;
    logic [LANES-1:0] fail;
    logic [LANES-1:0] rate;
    logic [LANES-1:0] rpt;
    logic [LANES-1:0] bad_pulse;
    logic [LANES-1:0] demux;
    logic [LANES-1:0] seen;
    logic [LANES-1:0] ferr_v;
    logic [LANES-1:0][6:0] run;
    logic [LANES-1:0][4:0] badh;
    logic [LANES-1:0][4:0] map;
    logic [LANES-1:0][2:0] inv;
    logic [LANES-1:0][15:0] spc;
    logic [LANES-1:0][3:0] ferr;
    logic [LANES-1:0][3:0] fcnt;
    logic [2:0] win;
    logic aligned;
    logic align_err;
    logic [2:0] tries;
    logic skew;
    logic link;
    logic fault;
    logic crc_bad;
    logic eop;
    logic perr;
    logic [6:0] bad_code;
    logic bypass;
    logic [15:0] mf_len;
    logic [IRQ_W-1:0] ists;
    logic [IRQ_W-1:0] ien;
    logic irq;
    logic [31:0] rdata;
  } state_t;

  state_t s;
  state_t n;

  ////////////////////////////////////////////////////////////////////////////////
  // marker identity compare, every lane against every table entry

  logic [LANES-1:0][LANES-1:0] hit;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    for (genvar k = 0; k < LANES; k++) begin : g_id
      assign hit[l][k] = ((lane_block[l][63:0] ^ RX_MARKER_RESET[k]) & MARKER_MASK) == '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [4:0] idx;
    logic ok;
    logic is_mk;
    logic drop;
    lane_err_t err;
    logic [LANES-1:0] mkv;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr_mask;
    logic clr_code;
    logic [3:0] fsum;
    idx = '0;
    ok = 1'b0;
    is_mk = 1'b0;
    drop = 1'b0;
    err = ERR_NONE;
    mkv = '0;
    ev = '0;
    clr_mask = '0;
    clr_code = 1'b0;
    fsum = '0;
    n = s;
    n.bad_pulse = '0;
    n.ferr_v = '0;
    n.skew = 1'b0;
    n.rdata = '0;
    n.win = s.win + 3'h1;

    for (int l = 0; l < LANES; l++) begin
      idx = '0;
      for (int k = 0; k < LANES; k++) begin
        if (hit[l][k]) begin
          idx = 5'(k);
        end
      end
      ok = ^lane_block[l][65:64];
      is_mk = (lane_block[l][65:64] == HDR_CTRL) && (|hit[l]);
      err = ERR_NONE;
      drop = 1'b0;
      fsum = s.fcnt[l] + {3'h0, lane_block_valid[l] & ~ok};
      n.fcnt[l] = fsum;
      if (s.win == FERR_WIN_LAST) begin
        n.ferr[l] = fsum;
        n.ferr_v[l] = 1'b1;
        n.fcnt[l] = '0;
      end
      if (lane_block_valid[l]) begin
        n.spc[l] = s.spc[l] + 16'h1;
        if (!s.lock[l]) begin
          // hunting: a full frame without lock counts as a failure
          n.run[l] = ok ? s.run[l] + 7'h1 : '0;
          if (s.spc[l] == s.mf_len) begin
            err = ERR_SYNC;
          end
          if (ok && s.run[l] == LOCK_GOOD_LAST) begin
            n.lock[l] = 1'b1;
            n.run[l] = '0;
            n.badh[l] = '0;
            n.spc[l] = '0;
            n.seen[l] = 1'b0;
            n.fail[l] = 1'b0;
            n.rate[l] = 1'b0;
            n.rpt[l] = 1'b0;
          end
        end else begin
          n.run[l] = s.run[l] + 7'h1;
          n.badh[l] = s.badh[l] + {4'h0, ~ok};
          if (s.run[l] == BER_WIN_LAST) begin
            n.badh[l] = {4'h0, ~ok};
          end
          if (s.badh[l] + {4'h0, ~ok} == BER_BAD_LIMIT) begin
            drop = 1'b1;
          end
          if (!ok && s.synced[l]) begin
            err = ERR_SYNC;
          end
          if (!s.seen[l]) begin
            if (is_mk) begin
              n.seen[l] = 1'b1;
              n.map[l] = idx;
              n.demux[l] = 1'b1;
              n.spc[l] = '0;
              n.inv[l] = '0;
            end else if (s.spc[l] == s.mf_len) begin
              err = ERR_SYNC;
            end
          end else if (s.spc[l] == s.mf_len - 16'h1) begin
            n.spc[l] = '0;
            if (is_mk && idx == s.map[l]) begin
              mkv[l] = 1'b1;
              n.inv[l] = '0;
              n.synced[l] = ~(s.fail[l] | s.rate[l] | s.rpt[l]);
            end else begin
              n.bad_pulse[l] = 1'b1;
              n.synced[l] = 1'b0;
              n.inv[l] = s.inv[l] + 3'h1;
              if (s.inv[l] == REPEAT_LAST) begin
                err = ERR_REPEAT;
              end
            end
          end else if (is_mk) begin
            err = ERR_RATE;
          end
        end
      end
      // a new error replaces the others and forces a fresh hunt
      if (err != ERR_NONE) begin
        n.fail[l] = (err == ERR_SYNC);
        n.rate[l] = (err == ERR_RATE);
        n.rpt[l] = (err == ERR_REPEAT);
        ev[IRQ_FAIL] = 1'b1;
        drop = 1'b1;
      end
      if (drop) begin
        n.lock[l] = 1'b0;
        n.synced[l] = 1'b0;
        n.seen[l] = 1'b0;
        n.demux[l] = 1'b0;
        n.run[l] = '0;
        n.spc[l] = '0;
        n.inv[l] = '0;
      end
    end

    // lanes arrive already deskewed in time, so markers must coincide
    if ((|mkv) && !(&mkv)) begin
      n.skew = 1'b1;
      ev[IRQ_SKEW] = 1'b1;
    end
    if (!(&n.synced) || n.skew) begin
      n.aligned = 1'b0;
    end else if (&mkv) begin
      n.aligned = 1'b1;
    end
    if (s.aligned && !n.aligned) begin
      n.align_err = 1'b1;
      ev[IRQ_ALIGN] = 1'b1;
    end else if (!s.aligned && n.aligned) begin
      n.align_err = 1'b0;
      n.tries = '0;
    end else if (n.skew && !s.aligned) begin
      n.tries = s.tries + 3'h1;
      if (s.tries == ALIGN_TRIES_LAST) begin
        n.align_err = 1'b1;
        n.tries = '0;
        ev[IRQ_ALIGN] = 1'b1;
      end
    end
    n.link = n.aligned & ~high_bit_error_rate;
    n.fault = internal_local_fault | received_local_fault;

    n.eop = pkt_valid & pkt_eop;
    n.crc_bad = pkt_valid & pkt_eop & (crc_calc != crc_rx);
    n.perr = pkt_valid & pkt_eop & (pkt_err_in | (n.crc_bad & ~s.bypass));
    ev[IRQ_CRC] = n.crc_bad;

    if (wr) begin
      if (addr == REG_CTRL) begin
        n.bypass = wdata[CTRL_BYPASS_BIT];
        clr_code = wdata[CTRL_CLR_BIT];
        n.mf_len = wdata[CTRL_MF_LSB +: 16];
      end else if (addr == REG_IRQ_ENABLE) begin
        n.ien = wdata[IRQ_W-1:0];
      end else if (addr == REG_IRQ_CLEAR) begin
        clr_mask = wdata[IRQ_W-1:0];
      end
    end

    // saturates so a long error burst never wraps to a small figure
    if (clr_code) begin
      n.bad_code = '0;
    end else if (rx_error_state && s.bad_code != BAD_CODE_MAX) begin
      n.bad_code = s.bad_code + 7'h1;
    end

    // an event in the clearing cycle stays set
    n.ists = (s.ists & ~clr_mask) | ev;
    n.irq = |(n.ists & n.ien);

    if (rd) begin
      if (addr == REG_CTRL) begin
        n.rdata = {s.mf_len, 14'h0, 1'b0, s.bypass};
      end else if (addr == REG_SUMMARY) begin
        n.rdata = {21'h0, s.bad_code, s.fault, s.link, s.align_err, s.aligned};
      end else if (addr == REG_SYNCED) begin
        n.rdata = {12'h0, s.synced};
      end else if (addr == REG_IRQ_STATUS) begin
        n.rdata = {28'h0, s.ists};
      end else if (addr == REG_IRQ_ENABLE) begin
        n.rdata = {28'h0, s.ien};
      end else if (addr[11:8] == PAGE_RX_MARKER && addr[7:3] < 5'(LANES)) begin
        n.rdata = RX_MARKER_RESET[addr[7:3]][addr[2] * 32 +: 32];
      end else if (addr[11:8] == PAGE_TX_MARKER && addr[7:3] < 5'(LANES)) begin
        n.rdata = TX_MARKER_RESET[addr[7:3]][addr[2] * 32 +: 32];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.mf_len <= MF_LEN_RESET;
      s.ien <= IEN_RESET;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata = s.rdata;
  assign irq = s.irq;
  assign lane_block_lock = s.lock;
  assign lane_word_synced = s.synced;
  assign lane_sync_failure = s.fail;
  assign marker_rate_error = s.rate;
  assign marker_repeat_error = s.rpt;
  assign invalid_marker_pulse = s.bad_pulse;
  assign lane_demux_found = s.demux;
  assign lane_position_map = s.map;
  assign framing_err_count = s.ferr;
  assign framing_err_valid = s.ferr_v;
  assign rx_aligned = s.aligned;
  assign rx_aligned_error = s.align_err;
  assign marker_skew_pulse = s.skew;
  assign rx_link_status = s.link;
  assign rx_local_fault = s.fault;
  assign crc_mismatch_pulse = s.crc_bad;
  assign packet_end_out = s.eop;
  assign packet_error_out = s.perr;
  assign bad_code_count = s.bad_code;

endmodule

/* bench/rx_lane_status_monitor.sv */
`timescale 1ns/1ps
module rx_lane_status_monitor
  import rx_lane_status_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched inputs
  input wire logic high_bit_error_rate,
  input wire logic internal_local_fault,
  input wire logic received_local_fault,
  input wire logic rx_error_state,
  input wire logic pkt_valid,
  input wire logic pkt_eop,
  input wire logic [31:0] crc_calc,
  input wire logic [31:0] crc_rx,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  // watched outputs
  input wire logic [LANES-1:0] lane_block_lock,
  input wire logic [LANES-1:0] lane_word_synced,
  input wire logic [LANES-1:0] lane_sync_failure,
  input wire logic [LANES-1:0] marker_rate_error,
  input wire logic [LANES-1:0] marker_repeat_error,
  input wire logic [LANES-1:0] invalid_marker_pulse,
  input wire logic [LANES-1:0] framing_err_valid,
  input wire logic rx_aligned,
  input wire logic marker_skew_pulse,
  input wire logic rx_link_status,
  input wire logic rx_local_fault,
  input wire logic crc_mismatch_pulse,
  input wire logic packet_end_out,
  input wire logic packet_error_out,
  input wire logic [6:0] bad_code_count
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // age keeps $past away from values latched during reset
  logic [1:0] age;
  logic clr_wr;
  logic bc_inc;
  assign clr_wr = wr && (addr == REG_CTRL) && wdata[CTRL_CLR_BIT];
  assign bc_inc = rx_error_state && (bad_code_count != BAD_CODE_MAX);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      age <= 2'h0;
    end else begin
      age <= {age[0], 1'b1};
    end
  end
  ////////////////////////////////////////
  sequence crc_bad;
    pkt_valid && pkt_eop && (crc_calc != crc_rx);
  endsequence
  sequence ferr_gap;
    !framing_err_valid[0] [*7] ##1 framing_err_valid[0];
  endsequence
  a_crc_pulse: assert property (crc_bad |=> crc_mismatch_pulse && packet_end_out)
    else $error("crc mismatch not flagged");
  a_err_with_end: assert property (packet_error_out |-> packet_end_out)
    else $error("packet error without end");
  a_link_status: assert property (age[0] && rx_link_status |->
    !$past(high_bit_error_rate) && (rx_aligned || $past(rx_aligned)))
    else $error("link status wrong");
  a_local_fault: assert property (age[0] |->
    rx_local_fault == $past(internal_local_fault || received_local_fault))
    else $error("local fault wrong");
  a_invalid_locked: assert property (age[0] |->
    (invalid_marker_pulse & ~$past(lane_block_lock)) == '0)
    else $error("invalid marker before lock");
  a_synced_locked: assert property ((lane_word_synced & ~lane_block_lock) == '0)
    else $error("synced without lock");
  a_flags_exclusive: assert property (((lane_sync_failure & marker_rate_error) |
    (lane_sync_failure & marker_repeat_error) | (marker_rate_error & marker_repeat_error)) == '0)
    else $error("two lane error flags");
  a_skew_unaligned: assert property (marker_skew_pulse |-> !rx_aligned)
    else $error("aligned during skew");
  a_ferr_period: assert property ($rose(framing_err_valid[0]) |=> ferr_gap)
    else $error("framing qualifier spacing");
  a_ferr_together: assert property (framing_err_valid == '0 || framing_err_valid == '1)
    else $error("framing qualifiers split");
  a_bad_code: assert property (age[1] && !$past(clr_wr) && !$past(clr_wr, 2) |->
    bad_code_count == $past(bad_code_count) + {6'h00, $past(bc_inc)})
    else $error("bad code count wrong");
endmodule

/* bench/lane_tx_model.sv */
`timescale 1ns/1ps
module lane_tx_model
  import rx_lane_status_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [15:0] mf_len,
  input wire logic [2:0] fault_sel,
  // lane words
  output logic [LANES-1:0][65:0] lane_block,
  output logic [LANES-1:0] lane_block_valid
);
  logic [15:0] cnt;
  logic [LANES-1:0] mk;
  logic [LANES-1:0][63:0] bad;
  logic [LANES-1:0][1:0] hdr;
  ////////////////////////////////////////
  // faults: 0 shifts lane 0 markers, 1 corrupts lane 1 markers, 2 breaks lane 2 headers
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      mk[l] = (l == 0 && fault_sel[0]) ? (cnt == 16'h0001) : (cnt == 16'h0000);
      bad[l] = (l == 1 && fault_sel[1]) ? 64'hffffff00_00000000 : 64'h0;
      hdr[l] = (l == 2 && fault_sel[2]) ? 2'h3 : 2'h1;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0000;
      lane_block <= '0;
      lane_block_valid <= '0;
    end else if (!run) begin
      // idle lines keep toggling so stale words never look valid
      lane_block <= ~lane_block;
      lane_block_valid <= '0;
    end else begin
      cnt <= (cnt == mf_len - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
      lane_block_valid <= '1;
      for (int l = 0; l < LANES; l++) begin
        if (mk[l]) begin
          lane_block[l] <= {HDR_CTRL, STD_MARKER[l] ^ bad[l]};
        end else begin
          lane_block[l] <= {hdr[l], 48'h0, cnt};
        end
      end
    end
  end
endmodule

/* bench/test_rx_lane_status.sv */
`timescale 1ns/1ps
module test_rx_lane_status
  import rx_lane_status_pkg::*;
;
  logic clock, rst, high_bit_error_rate, internal_local_fault, received_local_fault, run;
  logic rx_error_state, pkt_valid, pkt_eop, pkt_err_in, wr, rd, irq, rx_aligned;
  logic rx_aligned_error, marker_skew_pulse, rx_link_status, rx_local_fault;
  logic crc_mismatch_pulse, packet_end_out, packet_error_out;
  logic [LANES-1:0][65:0] lane_block;
  logic [LANES-1:0] lane_block_valid, lane_block_lock, lane_word_synced, lane_sync_failure;
  logic [LANES-1:0] marker_rate_error, marker_repeat_error, invalid_marker_pulse;
  logic [LANES-1:0] lane_demux_found, framing_err_valid;
  logic [LANES-1:0][4:0] lane_position_map;
  logic [LANES-1:0][3:0] framing_err_count;
  logic [31:0] crc_calc, crc_rx, wdata, rdata, rv, r;
  logic [AW-1:0] addr;
  logic [6:0] bad_code_count;
  logic [2:0] fault_sel;
  int failures, checks_done, seed, n;
  // short meta frame keeps relock times small
  // but must outlast the 64-word lock hunt, or a hunting lane always times out
  localparam logic [15:0] MF = 16'h0050;

  rx_lane_status rx_lane_status_inst (.*);
  lane_tx_model lane_tx_model_inst (.*, .mf_len(MF));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  ////////////////////////////////////////
  function automatic logic exp_err(input logic same, input logic byp);
    return !same && !byp;
  endfunction
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [AW-1:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic reg_rd(input logic [AW-1:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask
  task automatic wait_aligned();
    for (int c = 0; c < 3000 && rx_aligned !== 1'b1; c++) @(posedge clock);
    check("aligned", rx_aligned, 1'b1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #1500000;
    failures++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    seed = 29;
    failures = 0;
    checks_done = 0;
    rst = 1'b1;
    {high_bit_error_rate, internal_local_fault, received_local_fault, rx_error_state} = '0;
    {pkt_valid, pkt_eop, pkt_err_in, wr, rd, run, crc_calc, crc_rx, wdata, addr, fault_sel} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    reg_rd(REG_CTRL, rv);
    check("ctrl reset", rv, {MF_LEN_RESET, 16'h0000});
    for (int i = 0; i < LANES * 4; i++) begin
      reg_rd({i[1] ? PAGE_TX_MARKER : PAGE_RX_MARKER, 8'((i / 4) * 8 + (i % 2) * 4)}, rv);
      check("marker word", rv, STD_MARKER[i / 4][(i % 2) * 32 +: 32]);
    end
    reg_rd(12'h7fc, rv);
    check("unmapped", rv, 32'h0);
    $display("end of reset values");
    reg_wr(REG_CTRL, {MF, 16'h0000});
    reg_wr(REG_IRQ_ENABLE, 32'h1);
    run <= 1'b1;
    wait_aligned();
    check("synced", lane_word_synced, {LANES{1'b1}});
    check("demux", lane_demux_found, {LANES{1'b1}});
    check("lock", lane_block_lock, {LANES{1'b1}});
    check("link", rx_link_status, 1'b1);
    for (int l = 0; l < LANES; l++) check("map", lane_position_map[l], l);
    for (int c = 0; c < 10 && framing_err_valid[0] !== 1'b1; c++) @(posedge clock);
    check("ferr clean", |framing_err_count, 1'b0);
    high_bit_error_rate <= 1'b1;
    repeat (3) @(posedge clock);
    check("link hiber", rx_link_status, 1'b0);
    high_bit_error_rate <= 1'b0;
    $display("end of alignment");
    fault_sel <= 3'h2;
    n = 0;
    for (int c = 0; c < 600 && marker_repeat_error[1] !== 1'b1; c++) begin
      @(posedge clock);
      n += invalid_marker_pulse[1];
    end
    fault_sel <= 3'h0;
    check("repeat", marker_repeat_error[1], 1'b1);
    check("invalid count", n, 4);
    repeat (2) @(posedge clock);
    check("synced drop", lane_word_synced[1], 1'b0);
    wait_aligned();
    check("repeat clear", marker_repeat_error, '0);
    fault_sel <= 3'h4;
    repeat (200) @(posedge clock);
    check("sync fail", lane_sync_failure[2], 1'b1);
    check("lock lost", lane_block_lock[2], 1'b0);
    check("align lost", rx_aligned_error, 1'b1);
    for (int c = 0; c < 10 && framing_err_valid[2] !== 1'b1; c++) @(posedge clock);
    // one marker at most per window keeps a good header in it
    check("ferr count", framing_err_count[2] inside {4'h7, 4'h8}, 1'b1);
    check("ferr other", framing_err_count[0], 4'h0);
    fault_sel <= 3'h0;
    wait_aligned();
    check("fail clear", lane_sync_failure, '0);
    check("align err clear", rx_aligned_error, 1'b0);
    fault_sel <= 3'h1;
    for (int c = 0; c < 300 && marker_rate_error[0] !== 1'b1; c++) @(posedge clock);
    check("rate", marker_rate_error[0], 1'b1);
    for (int c = 0; c < 3000 && rx_aligned_error !== 1'b1; c++) @(posedge clock);
    check("skew tries", rx_aligned_error, 1'b1);
    reg_rd(REG_IRQ_STATUS, rv);
    check("skew status", rv[IRQ_SKEW], 1'b1);
    check("irq up", irq, 1'b1);
    fault_sel <= 3'h0;
    wait_aligned();
    reg_wr(REG_IRQ_CLEAR, 32'hf);
    @(posedge clock);
    check("irq cleared", irq, 1'b0);
    $display("end of lane errors");
    reg_wr(REG_IRQ_ENABLE, 32'h2);
    for (int t = 0; t < 24; t++) begin
      r = $random(seed);
      if (t < 4) r[1:0] = t[1:0];
      reg_wr(REG_CTRL, {MF, 15'h0000, r[0]});
      {pkt_valid, pkt_eop} <= 2'h3;
      crc_calc <= r;
      crc_rx <= r[1] ? r : ~r;
      @(posedge clock);
      {pkt_valid, pkt_eop} <= 2'h0;
      @(posedge clock);
      check("crc pulse", crc_mismatch_pulse, !r[1]);
      check("end out", packet_end_out, 1'b1);
      check("err out", packet_error_out, exp_err(r[1], r[0]));
    end
    check("irq crc", irq, 1'b1);
    reg_wr(REG_IRQ_ENABLE, 32'h0);
    check("irq masked", irq, 1'b0);
    reg_wr(REG_IRQ_CLEAR, 32'hf);
    reg_wr(REG_IRQ_ENABLE, 32'h2);
    check("irq clear", irq, 1'b0);
    $display("end of crc");
    reg_wr(REG_CTRL, {MF, 16'h0002});
    n = 0;
    for (int t = 0; t < 40; t++) begin
      r = $random(seed);
      {internal_local_fault, received_local_fault, rx_error_state} <= r[2:0];
      n += r[0];
      @(posedge clock);
    end
    {internal_local_fault, received_local_fault, rx_error_state} <= 3'h2;
    repeat (2) @(posedge clock);
    check("bad code", bad_code_count, n);
    check("local fault", rx_local_fault, 1'b1);
    reg_rd(REG_SUMMARY, rv);
    check("summary count", rv[10:4], n);
    rx_error_state <= 1'b1;
    repeat (140) @(posedge clock);
    check("saturate", bad_code_count, BAD_CODE_MAX);
    $display("end of counters");
    tally_and_finish();
  end
endmodule

bind rx_lane_status rx_lane_status_monitor rx_lane_status_monitor_inst (.*);
